// ### common/sec_pkg.sv
// shared constants and carrier types for the sram ecc wrapper
// assumes one 10 MHz clock, synchronous reset and byte-indexed registers
//
// What this block does
// - debug data register holds raw data to write and receives raw read data
// - debug check register holds raw check bits to write and receives raw read bits
// - command register always readable, writable only in special mode
// - command bit 7 set disables read repair; clear enables it
// - command bit 1 writes debug data and check bits raw at pointer, then clears
// - command bit 0 reads pointer raw into debug registers, then clears
// - both command bits written together: only the debug write runs
// - setting a command bit is ignored while either command bit is set
// - bus writes of 1 to 4 bytes per aligned word, check bits per halfword
// - aligned 2 and 4 byte writes take one cycle, no old-data check
// - other writes read and check first, then write merged bytes next cycle
// - partial write with single error merges corrected data and sets flag
// - partial write with double error leaves memory and reports error
// - single error read returns corrected data, writes it back, sets flag
// - read that repaired delays next back-to-back read by one cycle
// - double error read leaves memory and marks data invalid
// - single error requests interrupt only when enabled; double reported outward
// - single error flag readable, cleared only by writing one
// - each check bit is inverted parity of data masked by fixed mask
// - memory zero-filled with valid check bits at start, ready low until done
// - debug read does no check, no repair, no error indication
package sec_pkg;
    localparam int DATA_W = 16;
    localparam int CHK_W = 6;
    localparam int SYS_AW = 24;
    // parity masks, one per check bit
    localparam logic [15:0] CHK_MASK [0:5] = '{16'h443F, 16'h13C7, 16'hE1D1,
                                               16'hEE60, 16'h3E8A, 16'h993C};
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_IRQ_EN = 4'h1;
    localparam logic [3:0] IDX_FLAG = 4'h2;
    localparam logic [3:0] IDX_PTR_H = 4'h7;
    localparam logic [3:0] IDX_PTR_M = 4'h8;
    localparam logic [3:0] IDX_PTR_L = 4'h9;
    localparam logic [3:0] IDX_DATA_H = 4'hC;
    localparam logic [3:0] IDX_DATA_L = 4'hD;
    localparam logic [3:0] IDX_CHECK = 4'hE;
    localparam logic [3:0] IDX_CMD = 4'hF;
    // field positions
    localparam int CMD_RD_BIT = 0;
    localparam int CMD_WR_BIT = 1;
    localparam int CMD_RR_BIT = 7;
    localparam int FLAG_BIT = 0;
    // reset values
    localparam logic [23:0] PTR_RST = 24'h000000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [5:0] CHECK_RST = 6'h00;

    typedef struct packed {
        logic valid;
        logic write;
        logic [SYS_AW-1:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } sec_req_t;

    typedef struct packed {
        logic ack;
        logic rd_invalid;
        logic wr_err;
        logic [31:0] rdata;
    } sec_rsp_t;
endpackage : sec_pkg

// ### core/sec_encode.sv
// check bit generator for one 16-bit word
// assumes nothing beyond the shared masks
module sec_encode (
    input wire logic [15:0] data,
    output logic [5:0] chk
);
    // inverted parity of each masked slice
    genvar g;
    generate
        for (g = 0; g < sec_pkg::CHK_W; g++) begin : g_bit
            assign chk[g] = ~(^(data & sec_pkg::CHK_MASK[g]));
        end
    endgenerate
endmodule : sec_encode

// ### core/sec_decode.sv
// syndrome decoder and corrector for one stored word
// assumes the mask columns are distinct and of weight two or more
module sec_decode (
    input wire logic [15:0] data,
    input wire logic [5:0] chk,
    output logic [15:0] corr,
    output logic single,
    output logic double
);
    logic [5:0] exp_chk;
    logic [5:0] syn;
    logic [15:0] flip;
    logic chk_only;

    sec_encode u_enc (
        .data(data),
        .chk(exp_chk)
    );

    assign syn = exp_chk ^ chk;

    // a data bit is wrong when the syndrome equals its mask column
    genvar i;
    generate
        for (i = 0; i < sec_pkg::DATA_W; i++) begin : g_col
            assign flip[i] = syn == {sec_pkg::CHK_MASK[5][i], sec_pkg::CHK_MASK[4][i],
                                     sec_pkg::CHK_MASK[3][i], sec_pkg::CHK_MASK[2][i],
                                     sec_pkg::CHK_MASK[1][i], sec_pkg::CHK_MASK[0][i]};
        end
    endgenerate

    // a lone check bit in error leaves the data intact
    assign chk_only = (syn != 6'h00) && ((syn & (syn - 6'h01)) == 6'h00);
    assign corr = data ^ flip;
    assign single = (|flip) | chk_only;
    assign double = (syn != 6'h00) & ~single;
endmodule : sec_decode

// ### core/sec_top.sv
// sram ecc wrapper: memory, access sequencing, debug port and registers
// assumes initiators hold a request until ack, registers reached over avalon-mm
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
module sec_top #(
    parameter int WORD_AW = 10
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic special_mode,
    input wire sec_pkg::sec_req_t sys_req,
    output sec_pkg::sec_rsp_t sys_rsp,
    output logic irq_single,
    output logic dbl_err_pulse,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int DEPTH = 1 << WORD_AW;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_MERGE = 2'b10
    } sec_state_t;

    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic [21:0] mem_lo [0:DEPTH-1];
    logic [21:0] mem_hi [0:DEPTH-1];

    sec_state_t state_reg;
    logic [WORD_AW-1:0] init_cnt_reg;
    logic rdy_reg;
    logic hold_reg;
    logic [15:0] sav_lo_reg;
    logic [15:0] sav_hi_reg;
    logic sav_sgl_reg;
    logic sav_dbl_reg;
    logic [23:0] ptr_reg;
    logic [15:0] dbg_data_reg;
    logic [5:0] dbg_chk_reg;
    logic dbg_wr_reg;
    logic dbg_rd_reg;
    logic repair_dis_reg;
    logic irq_en_reg;
    logic flag_reg;
    logic wait_reg;

    // replace only the enabled bytes of a halfword
    function automatic logic [15:0] merge_half(input logic [15:0] old_d,
                                               input logic [15:0] new_d,
                                               input logic [1:0] en);
        merge_half = {en[1] ? new_d[15:8] : old_d[15:8], en[0] ? new_d[7:0] : old_d[7:0]};
    endfunction : merge_half

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    logic [WORD_AW-1:0] req_idx;
    logic [WORD_AW-1:0] dbg_idx;
    logic [WORD_AW-1:0] acc_idx;
    logic [WORD_AW-1:0] wr_idx;
    logic accept;
    logic acc_rd;
    logic acc_wr;
    logic partial;
    logic use_dbg;
    logic dbg_do_wr;
    logic dbg_do_rd;

    assign req_idx = sys_req.addr[WORD_AW+1:2];
    assign dbg_idx = ptr_reg[WORD_AW+1:2];
    // a held request is not taken again while its ack is out
    assign accept = (state_reg == ST_IDLE) && !hold_reg && sys_req.valid && !sys_rsp.ack;
    assign acc_rd = accept && !sys_req.write;
    assign acc_wr = accept && sys_req.write;
    assign partial = (^sys_req.be[1:0]) | (^sys_req.be[3:2]);
    // debug runs only when no system access wants the memory
    assign use_dbg = (state_reg == ST_IDLE) && !hold_reg && !sys_req.valid
                     && (dbg_wr_reg || dbg_rd_reg);
    assign dbg_do_wr = use_dbg && dbg_wr_reg;
    assign dbg_do_rd = use_dbg && !dbg_wr_reg;
    assign acc_idx = use_dbg ? dbg_idx : req_idx;
    assign wr_idx = (state_reg == ST_INIT) ? init_cnt_reg : acc_idx;

    // ----------------------------------------------------------------
    // read path and decoders
    // ----------------------------------------------------------------
    logic [21:0] rd_lo;
    logic [21:0] rd_hi;
    logic [15:0] corr_lo;
    logic [15:0] corr_hi;
    logic sgl_lo;
    logic sgl_hi;
    logic dbl_lo;
    logic dbl_hi;

    assign rd_lo = mem_lo[acc_idx];
    assign rd_hi = mem_hi[acc_idx];

    sec_decode u_dec_lo (
        .data(rd_lo[15:0]),
        .chk(rd_lo[21:16]),
        .corr(corr_lo),
        .single(sgl_lo),
        .double(dbl_lo)
    );

    sec_decode u_dec_hi (
        .data(rd_hi[15:0]),
        .chk(rd_hi[21:16]),
        .corr(corr_hi),
        .single(sgl_hi),
        .double(dbl_hi)
    );

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    logic we_lo;
    logic we_hi;
    logic [15:0] wd_lo;
    logic [15:0] wd_hi;
    logic [5:0] enc_lo;
    logic [5:0] enc_hi;
    logic [21:0] ent_lo;
    logic [21:0] ent_hi;
    logic repair;

    assign repair = acc_rd && !repair_dis_reg;

    // select what each half stores this cycle
    always_comb begin
        we_lo = 1'b0;
        we_hi = 1'b0;
        wd_lo = 16'h0000;
        wd_hi = 16'h0000;
        if (state_reg == ST_INIT) begin
            we_lo = 1'b1;
            we_hi = 1'b1;
        end else if (state_reg == ST_MERGE) begin
            we_lo = !sav_dbl_reg && (|sys_req.be[1:0]);
            we_hi = !sav_dbl_reg && (|sys_req.be[3:2]);
            wd_lo = merge_half(sav_lo_reg, sys_req.wdata[15:0], sys_req.be[1:0]);
            wd_hi = merge_half(sav_hi_reg, sys_req.wdata[31:16], sys_req.be[3:2]);
        end else if (acc_wr && !partial) begin
            we_lo = &sys_req.be[1:0];
            we_hi = &sys_req.be[3:2];
            wd_lo = sys_req.wdata[15:0];
            wd_hi = sys_req.wdata[31:16];
        end else if (repair) begin
            we_lo = sgl_lo;
            we_hi = sgl_hi;
            wd_lo = corr_lo;
            wd_hi = corr_hi;
        end else if (dbg_do_wr) begin
            we_lo = !ptr_reg[1];
            we_hi = ptr_reg[1];
        end
    end

    sec_encode u_enc_lo (
        .data(wd_lo),
        .chk(enc_lo)
    );

    sec_encode u_enc_hi (
        .data(wd_hi),
        .chk(enc_hi)
    );

    // debug writes store the raw pair untouched
    assign ent_lo = dbg_do_wr ? {dbg_chk_reg, dbg_data_reg} : {enc_lo, wd_lo};
    assign ent_hi = dbg_do_wr ? {dbg_chk_reg, dbg_data_reg} : {enc_hi, wd_hi};

    // memory arrays
    always_ff @(posedge mclk) begin
        if (we_lo) begin
            mem_lo[wr_idx] <= ent_lo;
        end
        if (we_hi) begin
            mem_hi[wr_idx] <= ent_hi;
        end
    end

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_INIT;
            init_cnt_reg <= '0;
            rdy_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_INIT: begin
                    init_cnt_reg <= init_cnt_reg + 1'b1;
                    if (init_cnt_reg == WORD_AW'(DEPTH - 1)) begin
                        rdy_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (acc_wr && partial) begin
                        state_reg <= ST_MERGE;
                    end
                end
                ST_MERGE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_INIT;
                end
            endcase
        end
    end

    // old data captured in the read cycle of a partial write
    always_ff @(posedge mclk) begin
        if (srst) begin
            sav_lo_reg <= 16'h0000;
            sav_hi_reg <= 16'h0000;
            sav_sgl_reg <= 1'b0;
            sav_dbl_reg <= 1'b0;
        end else if (acc_wr && partial) begin
            sav_lo_reg <= corr_lo;
            sav_hi_reg <= corr_hi;
            sav_sgl_reg <= (^sys_req.be[1:0] & sgl_lo) | (^sys_req.be[3:2] & sgl_hi);
            sav_dbl_reg <= (^sys_req.be[1:0] & dbl_lo) | (^sys_req.be[3:2] & dbl_hi);
        end
    end

    // one idle cycle after a read that repaired memory
    always_ff @(posedge mclk) begin
        if (srst) begin
            hold_reg <= 1'b0;
        end else begin
            hold_reg <= (repair && (sgl_lo || sgl_hi)) || (hold_reg && sys_rsp.ack);
        end
    end

    // ----------------------------------------------------------------
    // system response
    // ----------------------------------------------------------------
    logic sgl_evt;
    logic dbl_evt;

    assign sgl_evt = (acc_rd && (sgl_lo || sgl_hi))
                     || (state_reg == ST_MERGE && sav_sgl_reg && !sav_dbl_reg);
    assign dbl_evt = (acc_rd && (dbl_lo || dbl_hi))
                     || (state_reg == ST_MERGE && sav_dbl_reg);

    // ack one cycle after the last access cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            sys_rsp <= '0;
        end else begin
            sys_rsp.ack <= acc_rd || (acc_wr && !partial) || (state_reg == ST_MERGE);
            sys_rsp.rd_invalid <= acc_rd && (dbl_lo || dbl_hi);
            sys_rsp.wr_err <= (state_reg == ST_MERGE) && sav_dbl_reg;
            if (acc_rd) begin
                sys_rsp.rdata <= {corr_hi, corr_lo};
            end
        end
    end

    // double errors leave the block for chip-level handling
    always_ff @(posedge mclk) begin
        if (srst) begin
            dbl_err_pulse <= 1'b0;
        end else begin
            dbl_err_pulse <= dbl_evt;
        end
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic [3:0] reg_idx;
    logic bus_wr;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;

    assign reg_idx = avs_address[5:2];
    assign bus_wr = avs_write && !wait_reg && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // read mux, unmapped reads as zero
    always_comb begin
        case (reg_idx)
            sec_pkg::IDX_STATUS: rd_mux = {7'h00, rdy_reg};
            sec_pkg::IDX_IRQ_EN: rd_mux = {7'h00, irq_en_reg};
            sec_pkg::IDX_FLAG: rd_mux = {7'h00, flag_reg};
            sec_pkg::IDX_PTR_H: rd_mux = ptr_reg[23:16];
            sec_pkg::IDX_PTR_M: rd_mux = ptr_reg[15:8];
            sec_pkg::IDX_PTR_L: rd_mux = ptr_reg[7:0];
            sec_pkg::IDX_DATA_H: rd_mux = dbg_data_reg[15:8];
            sec_pkg::IDX_DATA_L: rd_mux = dbg_data_reg[7:0];
            sec_pkg::IDX_CHECK: rd_mux = {2'b00, dbg_chk_reg};
            sec_pkg::IDX_CMD: rd_mux = {repair_dis_reg, 5'h00, dbg_wr_reg, dbg_rd_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // one wait state, then data and strobe released together
    always_ff @(posedge mclk) begin
        if (srst) begin
            wait_reg <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if ((avs_read || avs_write) && wait_reg) begin
            wait_reg <= 1'b0;
            avs_readdata <= {24'h000000, rd_mux};
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign avs_waitrequest = wait_reg;

    // pointer and interrupt enable
    always_ff @(posedge mclk) begin
        if (srst) begin
            ptr_reg <= sec_pkg::PTR_RST;
            irq_en_reg <= 1'b0;
        end else if (bus_wr) begin
            case (reg_idx)
                sec_pkg::IDX_PTR_H: ptr_reg[23:16] <= wbyte;
                sec_pkg::IDX_PTR_M: ptr_reg[15:8] <= wbyte;
                sec_pkg::IDX_PTR_L: ptr_reg[7:0] <= {wbyte[7:1], 1'b0};
                sec_pkg::IDX_IRQ_EN: irq_en_reg <= wbyte[0];
                default: ptr_reg <= ptr_reg;
            endcase
        end
    end

    // debug data and check registers, loaded by a debug read
    always_ff @(posedge mclk) begin
        if (srst) begin
            dbg_data_reg <= sec_pkg::DATA_RST;
            dbg_chk_reg <= sec_pkg::CHECK_RST;
        end else if (dbg_do_rd) begin
            dbg_data_reg <= ptr_reg[1] ? rd_hi[15:0] : rd_lo[15:0];
            dbg_chk_reg <= ptr_reg[1] ? rd_hi[21:16] : rd_lo[21:16];
        end else if (bus_wr) begin
            if (reg_idx == sec_pkg::IDX_DATA_H) begin
                dbg_data_reg[15:8] <= wbyte;
            end
            if (reg_idx == sec_pkg::IDX_DATA_L) begin
                dbg_data_reg[7:0] <= wbyte;
            end
            if (reg_idx == sec_pkg::IDX_CHECK) begin
                dbg_chk_reg <= wbyte[5:0];
            end
        end
    end

    // debug command bits
    always_ff @(posedge mclk) begin
        if (srst) begin
            dbg_wr_reg <= 1'b0;
            dbg_rd_reg <= 1'b0;
            repair_dis_reg <= 1'b0;
        end else begin
            if (use_dbg) begin
                dbg_wr_reg <= 1'b0;
                dbg_rd_reg <= dbg_wr_reg & dbg_rd_reg;
            end
            if (bus_wr && special_mode && reg_idx == sec_pkg::IDX_CMD) begin
                repair_dis_reg <= wbyte[sec_pkg::CMD_RR_BIT];
                if (!dbg_wr_reg && !dbg_rd_reg) begin
                    if (wbyte[sec_pkg::CMD_WR_BIT]) begin
                        dbg_wr_reg <= 1'b1;
                    end else if (wbyte[sec_pkg::CMD_RD_BIT]) begin
                        dbg_rd_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // single error flag, a new error beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_reg <= 1'b0;
            irq_single <= 1'b0;
        end else begin
            if (sgl_evt) begin
                flag_reg <= 1'b1;
            end else if (bus_wr && reg_idx == sec_pkg::IDX_FLAG && wbyte[sec_pkg::FLAG_BIT]) begin
                flag_reg <= 1'b0;
            end
            irq_single <= (flag_reg || sgl_evt) && irq_en_reg;
        end
    end
endmodule : sec_top

// ### verif/sec_top_assertions.sv
// port checker for the sram ecc wrapper
// assumes binding to sec_top, srst synchronous active high
module sec_top_assertions (
    input wire logic mclk,
    input wire logic srst,
    input wire sec_pkg::sec_req_t sys_req,
    input wire sec_pkg::sec_rsp_t sys_rsp,
    input wire logic irq_single,
    input wire logic dbl_err_pulse,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // --------
    // register bus answers
    // --------
    avs_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long grant");
    read_upper_a: assert property (!avs_waitrequest && avs_read
        |-> avs_readdata[31:8] == 24'h000000) else $error("upper bits");
    read_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("data moved");
    // --------
    // system port answers
    // --------
    ack_once_a: assert property (sys_rsp.ack |=> !sys_rsp.ack)
        else $error("long ack");
    ack_held_a: assert property (sys_rsp.ack |-> sys_req.valid)
        else $error("stray ack");
    invalid_read_a: assert property (sys_rsp.rd_invalid
        |-> sys_rsp.ack && !sys_req.write && dbl_err_pulse) else $error("bad invalid");
    blocked_write_a: assert property (sys_rsp.wr_err |-> sys_rsp.ack && sys_req.write)
        else $error("bad write error");
    ack_bound_a: assert property ($rose(sys_req.valid) |-> ##[1:40] sys_rsp.ack)
        else $error("no ack");
    // main scenarios
    invalid_c: cover property (sys_rsp.rd_invalid);
    blocked_c: cover property (sys_rsp.wr_err);
    irq_c: cover property (irq_single);
endmodule : sec_top_assertions

bind sec_top sec_top_assertions sec_top_assertions_i (.mclk(mclk), .srst(srst),
    .sys_req(sys_req), .sys_rsp(sys_rsp), .irq_single(irq_single),
    .dbl_err_pulse(dbl_err_pulse), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// ### verif/sec_initiator.sv
// system bus initiator model
// assumes go pulses one cycle
module sec_initiator (
    input wire logic mclk,
    input wire logic go,
    input wire sec_pkg::sec_req_t cmd,
    input wire sec_pkg::sec_rsp_t sys_rsp,
    output sec_pkg::sec_req_t sys_req,
    output sec_pkg::sec_rsp_t got,
    output logic done,
    output int lat
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sys_req = '0;
        done = 1'b0;
        lat = 0;
    end
    // hold request until ack, count waits
    always @(posedge mclk) begin
        done <= 1'b0;
        if (go) begin
            sys_req <= cmd;
            lat <= 0;
        end else if (sys_req.valid && sys_rsp.ack === 1'b1) begin
            sys_req.valid <= 1'b0;
            sys_req.wdata <= ~sys_req.wdata;
            got <= sys_rsp;
            done <= 1'b1;
        end else if (sys_req.valid) begin
            lat <= lat + 1;
        end
    end
endmodule : sec_initiator

// ### verif/sram_ecc_access_and_debug_test.sv
// bench for the sram ecc wrapper
// assumes sec_top with WORD_AW 4 and the initiator model
module sram_ecc_access_and_debug_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic special_mode = 1'b1;
    logic go = 1'b0;
    sec_pkg::sec_req_t cmd = '0;
    sec_pkg::sec_req_t sys_req;
    sec_pkg::sec_rsp_t sys_rsp;
    sec_pkg::sec_rsp_t got;
    logic irq_single;
    logic done;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] q;
    logic [15:0] d = 16'h00F0;
    int lat;
    int mismatches = 0;
    int n_tests = 0;
    always #50 mclk = ~mclk;
    sec_top #(.WORD_AW(4)) sec_top_i (.mclk(mclk), .srst(srst), .special_mode(special_mode),
        .sys_req(sys_req), .sys_rsp(sys_rsp), .irq_single(irq_single), .dbl_err_pulse(),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(4'h1), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    sec_initiator sec_initiator_i (.mclk(mclk), .go(go), .cmd(cmd), .sys_rsp(sys_rsp),
        .sys_req(sys_req), .got(got), .done(done), .lat(lat));
    // --------
    // shared tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [5:0] ecc(input logic [15:0] v);
        for (int i = 0; i < 6; i++) begin
            ecc[i] = ~^(v & sec_pkg::CHK_MASK[i]);
        end
    endfunction : ecc
    task automatic acc(input logic [3:0] idx, input logic wr, input logic [7:0] v);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, v};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : acc
    task automatic sys(input logic wr, input logic [3:0] be, input logic [23:0] a,
                       input logic [31:0] wd, input int exp_lat);
        @(posedge mclk);
        cmd <= '{valid: 1'b1, write: wr, addr: a, be: be, wdata: wd};
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        do @(posedge mclk); while (done !== 1'b1);
        check(lat, exp_lat);
    endtask : sys
    task automatic dbg(input logic [7:0] c, input logic [15:0] v, input logic [5:0] e);
        acc(sec_pkg::IDX_PTR_L, 1'b1, 8'h08);
        acc(sec_pkg::IDX_DATA_H, 1'b1, v[15:8]);
        acc(sec_pkg::IDX_DATA_L, 1'b1, v[7:0]);
        acc(sec_pkg::IDX_CHECK, 1'b1, {2'b00, e});
        acc(sec_pkg::IDX_CMD, 1'b1, c);
        do acc(sec_pkg::IDX_CMD, 1'b0, 8'h00); while (q[1:0] !== 2'b00);
    endtask : dbg
    task automatic chk_raw(input logic [7:0] c, input logic [15:0] v, input logic [5:0] e);
        dbg(c, ~v, 6'h00);
        acc(sec_pkg::IDX_DATA_H, 1'b0, 8'h00);
        check(q, v[15:8]);
        acc(sec_pkg::IDX_DATA_L, 1'b0, 8'h00);
        check(q, v[7:0]);
        acc(sec_pkg::IDX_CHECK, 1'b0, 8'h00);
        check(q, {2'b00, e});
    endtask : chk_raw
    task automatic flag_is(input logic [7:0] v);
        acc(sec_pkg::IDX_FLAG, 1'b0, 8'h00);
        check(q, v);
    endtask : flag_is
    // --------
    // scenarios
    // --------
    task automatic t_init();
        do acc(sec_pkg::IDX_STATUS, 1'b0, 8'h00); while (q !== 8'h01);
        check(q, 8'h01);
        acc(sec_pkg::IDX_CMD, 1'b0, 8'h00);
        check(q, 8'h00);
        acc(4'h3, 1'b1, 8'hFF);
        acc(4'h3, 1'b0, 8'h00);
        check(q, 8'h00);
        acc(sec_pkg::IDX_CHECK, 1'b1, 8'hFF);
        acc(sec_pkg::IDX_CHECK, 1'b0, 8'h00);
        check(q, 8'h3F);
        sys(1'b0, 4'h0, 24'h14, 32'h0, 1);
        check(got.rdata, 32'h0);
        $display("init done");
    endtask : t_init
    task automatic t_writes();
        sys(1'b1, 4'hF, 24'h4, 32'h12345678, 1);
        sys(1'b1, 4'h2, 24'h4, 32'h0000AB00, 2);
        sys(1'b1, 4'hE, 24'h4, 32'h11223344, 2);
        sys(1'b0, 4'h0, 24'h4, 32'h0, 1);
        check(got.rdata, 32'h11223378);
        $display("writes done");
    endtask : t_writes
    task automatic t_single();
        dbg(8'h02, d ^ 16'h0001, ecc(d));
        sys(1'b0, 4'h0, 24'h8, 32'h0, 1);
        check(got.rdata[15:0], d);
        check(got.rd_invalid, 1'b0);
        flag_is(8'h01);
        acc(sec_pkg::IDX_IRQ_EN, 1'b1, 8'h01);
        repeat (2) @(posedge mclk);
        check(irq_single, 1'b1);
        acc(sec_pkg::IDX_FLAG, 1'b1, 8'h01);
        flag_is(8'h00);
        chk_raw(8'h01, d, ecc(d));
        $display("single done");
    endtask : t_single
    task automatic t_norepair();
        dbg(8'h82, d ^ 16'h0001, ecc(d));
        sys(1'b0, 4'h0, 24'h8, 32'h0, 1);
        check(got.rdata[15:0], d);
        acc(sec_pkg::IDX_FLAG, 1'b1, 8'h01);
        chk_raw(8'h81, d ^ 16'h0001, ecc(d));
        flag_is(8'h00);
        sys(1'b1, 4'h1, 24'h8, 32'h00000055, 2);
        sys(1'b0, 4'h0, 24'h8, 32'h0, 1);
        check(got.rdata[15:0], {d[15:8], 8'h55});
        flag_is(8'h01);
        $display("norepair done");
    endtask : t_norepair
    task automatic t_double();
        dbg(8'h02, d ^ 16'h0003, ecc(d));
        sys(1'b0, 4'h0, 24'h8, 32'h0, 1);
        check(got.rd_invalid, 1'b1);
        sys(1'b1, 4'h1, 24'h8, 32'h000000AA, 2);
        check(got.wr_err, 1'b1);
        chk_raw(8'h01, d ^ 16'h0003, ecc(d));
        $display("double done");
    endtask : t_double
    task automatic t_cmd();
        dbg(8'h03, 16'h5A5A, ecc(16'h5A5A));
        sys(1'b0, 4'h0, 24'h8, 32'h0, 1);
        check(got.rdata[15:0], 16'h5A5A);
        special_mode <= 1'b0;
        acc(sec_pkg::IDX_CMD, 1'b1, 8'h80);
        acc(sec_pkg::IDX_CMD, 1'b0, 8'h00);
        check(q, 8'h00);
        $display("cmd done");
    endtask : t_cmd
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_init();
        t_writes();
        t_single();
        t_norepair();
        t_double();
        t_cmd();
        conclude();
    end
    // watchdog
    initial begin
        #2000000;
        mismatches++;
        conclude();
    end
endmodule : sram_ecc_access_and_debug_test
